/* gild_gpio_irq.sv */
// module: gpio interrupt latch, de-bounce and raw-state register block
// ----------------------------------------------------------------------
// Summary of operation
// [R01] qualifying pin event sets a sticky latch
// [R02] writing one clears that pin's latch
// [R03] writing zero leaves latch unchanged
// [R04] latch-clear register always reads zero
// [R05] latches unreadable; only combined interrupt visible
// [R06] host enables one pin at a time
// [R07] persisting active level re-sets latch immediately
// [R08] de-bounce sits before event detection
// [R09] filtered change passes after two slow samples
// [R10] enable bit one filters, zero bypasses
// [R11] raw-state bits show pin levels
// [R12] host writes zero to reserved bits
// [R13] mode bit: zero level, one edge
// [R14] both-edge bit overrides sense in edge mode
// [R15] event beats coincident clear
// ----------------------------------------------------------------------
//
// The strobed register port was chosen for this implementation.
module gild_gpio_irq #(
  parameter int PINS = gild_pkg::PIN_COUNT,
  parameter int SLOW_DIV = gild_pkg::SLOW_DIV_CYCLES
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [PINS-1:0] GPIO_IN,
  input wire logic [gild_pkg::ADDR_W-1:0] ADDR,
  input wire logic [gild_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [gild_pkg::DATA_W-1:0] RDATA,
  output logic IRQ
);
  localparam int DIV_W = $clog2(SLOW_DIV + 1);

  typedef struct packed {
    logic [PINS-1:0] dbe;
    logic [PINS-1:0] mode;
    logic [PINS-1:0] sense;
    logic [PINS-1:0] both;
    logic [PINS-1:0] ien;
    logic [PINS-1:0] latch;
    logic [PINS-1:0] prev;
    logic [PINS-1:0] raw;
    logic [DIV_W-1:0] div;
    logic tick;
    logic [gild_pkg::DATA_W-1:0] rdata;
    logic irq;
  } gild_state_t;

  gild_state_t st_r;
  gild_state_t st_nxt;
  logic rst_meta_r;
  logic rst_sync_r;
  logic [PINS-1:0] filt;
  logic [PINS-1:0] edge_hit;
  logic [PINS-1:0] level_hit;
  logic [PINS-1:0] event_hit;
  logic [PINS-1:0] clr_mask;

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // input filter
  // ----------------------------------------------------------------------
  gild_debounce #(
    .PINS(PINS)
  ) u_debounce (
    .clk(MCLK),
    .rst_n(rst_sync_r),
    .tick(st_r.tick),
    .pin_in(GPIO_IN),
    .enable(st_r.dbe),
    .pin_out(filt)
  ); // [R08]

  // ----------------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < PINS; i++)
    begin
      // sense one selects rising edge or high level
      if (st_r.both[i])
        edge_hit[i] = filt[i] ^ st_r.prev[i]; // [R14]
      else if (st_r.sense[i])
        edge_hit[i] = filt[i] & ~st_r.prev[i];
      else
        edge_hit[i] = ~filt[i] & st_r.prev[i];
      level_hit[i] = ~(filt[i] ^ st_r.sense[i]);
      // level mode keeps firing while active, so a clear cannot stick
      event_hit[i] = st_r.ien[i] &
        (st_r.mode[i] ? edge_hit[i] : level_hit[i]); // [R13] [R07] [R01]
    end
  end

  assign clr_mask = (WR && ADDR == gild_pkg::OFF_IRQ_LATCH_CLEAR) ?
    WDATA[gild_pkg::FLD_PIN_LSB +: PINS] : '0; // [R02] [R03]

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.prev = filt;
    st_nxt.raw = GPIO_IN; // [R11]
    // slow tick divider
    if (st_r.div == DIV_W'(SLOW_DIV - 1))
    begin
      st_nxt.div = '0;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.div = st_r.div + DIV_W'(1);
      st_nxt.tick = 1'b0;
    end
    // set wins over a clear in the same cycle
    st_nxt.latch = (st_r.latch & ~clr_mask) | event_hit; // [R01] [R15]
    st_nxt.irq = |st_nxt.latch; // [R05]
    if (WR)
    begin
      case (ADDR)
        gild_pkg::OFF_IRQ_DEBOUNCE_ENABLE:
          st_nxt.dbe = WDATA[gild_pkg::FLD_PIN_LSB +: PINS]; // [R10]
        gild_pkg::OFF_IRQ_MODE_SELECT:
          st_nxt.mode = WDATA[gild_pkg::FLD_PIN_LSB +: PINS];
        gild_pkg::OFF_IRQ_SENSE_SELECT:
          st_nxt.sense = WDATA[gild_pkg::FLD_PIN_LSB +: PINS];
        gild_pkg::OFF_IRQ_BOTH_EDGE_SELECT:
          st_nxt.both = WDATA[gild_pkg::FLD_PIN_LSB +: PINS];
        gild_pkg::OFF_IRQ_ENABLE:
          st_nxt.ien = WDATA[gild_pkg::FLD_PIN_LSB +: PINS];
        default:
          st_nxt.ien = st_r.ien;
      endcase
    end
    // read data stands only in the cycle after the strobe
    st_nxt.rdata = '0;
    if (RD)
    begin
      case (ADDR)
        gild_pkg::OFF_IRQ_LATCH_CLEAR:
          st_nxt.rdata = '0; // [R04]
        gild_pkg::OFF_IRQ_DEBOUNCE_ENABLE:
          st_nxt.rdata[gild_pkg::FLD_PIN_LSB +: PINS] = st_r.dbe;
        gild_pkg::OFF_PIN_RAW_STATE:
          st_nxt.rdata[gild_pkg::FLD_PIN_LSB +: PINS] = st_r.raw; // [R11]
        gild_pkg::OFF_IRQ_MODE_SELECT:
          st_nxt.rdata[gild_pkg::FLD_PIN_LSB +: PINS] = st_r.mode;
        gild_pkg::OFF_IRQ_SENSE_SELECT:
          st_nxt.rdata[gild_pkg::FLD_PIN_LSB +: PINS] = st_r.sense;
        gild_pkg::OFF_IRQ_BOTH_EDGE_SELECT:
          st_nxt.rdata[gild_pkg::FLD_PIN_LSB +: PINS] = st_r.both;
        gild_pkg::OFF_IRQ_ENABLE:
          st_nxt.rdata[gild_pkg::FLD_PIN_LSB +: PINS] = st_r.ien;
        default:
          st_nxt.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      st_r <= '0;
      st_r.dbe <= gild_pkg::RST_DEBOUNCE_ENABLE;
      st_r.mode <= gild_pkg::RST_MODE;
      st_r.sense <= gild_pkg::RST_SENSE;
      st_r.both <= gild_pkg::RST_BOTH_EDGE;
      st_r.ien <= gild_pkg::RST_IRQ_ENABLE;
    end
    else
      st_r <= st_nxt;
  end

  assign RDATA = st_r.rdata;
  assign IRQ = st_r.irq;
endmodule // gild_gpio_irq

/* gild_pkg.sv */
// package: register map, field layout and reset values of the gpio irq block
package gild_pkg;
  localparam int PIN_COUNT = 9;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] OFF_IRQ_LATCH_CLEAR = 8'h20;
  localparam logic [7:0] OFF_IRQ_DEBOUNCE_ENABLE = 8'h24;
  localparam logic [7:0] OFF_PIN_RAW_STATE = 8'h28;
  localparam logic [7:0] OFF_IRQ_MODE_SELECT = 8'h30;
  localparam logic [7:0] OFF_IRQ_SENSE_SELECT = 8'h34;
  localparam logic [7:0] OFF_IRQ_BOTH_EDGE_SELECT = 8'h38;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h3C;
  // field position: per-pin bits start at bit 0
  localparam int FLD_PIN_LSB = 0;
  // reset values
  localparam logic [8:0] RST_DEBOUNCE_ENABLE = 9'h000;
  localparam logic [8:0] RST_MODE = 9'h000;
  localparam logic [8:0] RST_SENSE = 9'h000;
  localparam logic [8:0] RST_BOTH_EDGE = 9'h000;
  localparam logic [8:0] RST_IRQ_ENABLE = 9'h000;
  // slow (kilohertz) sampling tick: period in ns and derived cycles
  localparam int SLOW_PERIOD_NS = 1000000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SLOW_DIV_CYCLES = SLOW_PERIOD_NS / CLK_PERIOD_NS;
  // samples a change must persist for before it is passed on
  localparam int DEBOUNCE_SAMPLES = 2;
endpackage : gild_pkg

/* gild_debounce.sv */
// module: per-pin two-sample de-bounce filter on the slow tick
module gild_debounce #(
  parameter int PINS = 9
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [PINS-1:0] pin_in,
  input wire logic [PINS-1:0] enable,
  output logic [PINS-1:0] pin_out
);
  typedef struct packed {
    logic [PINS-1:0] stable;
    logic [PINS-1:0] cand;
    logic [PINS-1:0] seen;
  } gild_db_state_t;

  gild_db_state_t st_r;
  gild_db_state_t st_nxt;

  // --------------------------------------------------------------
  // filter
  // --------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    if (tick)
    begin
      for (int i = 0; i < PINS; i++)
      begin
        // a change must be sampled on two successive ticks
        if (pin_in[i] == st_r.stable[i])
          st_nxt.seen[i] = 1'b0;
        else if (st_r.seen[i] && st_r.cand[i] == pin_in[i])
        begin
          st_nxt.stable[i] = pin_in[i]; // [R09]
          st_nxt.seen[i] = 1'b0;
        end
        else
        begin
          st_nxt.cand[i] = pin_in[i];
          st_nxt.seen[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // bypassed pins go straight through; filter tracks anyway
  assign pin_out = (enable & st_r.stable) | (~enable & pin_in); // [R10]
endmodule // gild_debounce

/* gild_checker.sv */
// checker: port-level assertions for the gpio irq block
module gild_checker #(
  parameter int PINS = 9
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [PINS-1:0] GPIO_IN,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic IRQ
);
  logic [8:0] dbe_r;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  // shadow of the filter enables, to judge read-back
  always_ff @(posedge MCLK or negedge RST_N)
    if (!RST_N)
      dbe_r <= 9'h000;
    else if (WR && ADDR == 8'h24)
      dbe_r <= WDATA[8:0];
  property p_clr_rd;
    RD && ADDR == 8'h20 |=> RDATA == 32'h0000_0000;
  endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("clear reads nonzero");
  property p_raw;
    RD && ADDR == 8'h28 |=> RDATA[PINS-1:0] == $past(GPIO_IN, 2);
  endproperty
  a_raw: assert property (p_raw) else $error("raw state wrong");
  property p_upper;
    RD |=> RDATA[31:9] == 23'h00_0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_unmap;
    RD && !(ADDR inside {8'h20, 8'h24, 8'h28, 8'h30, 8'h34, 8'h38, 8'h3C})
      |=> RDATA == 32'h0000_0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  property p_idle;
    !RD |=> RDATA == 32'h0000_0000;
  endproperty
  a_idle: assert property (p_idle) else $error("data without read");
  property p_sticky;
    $fell(IRQ) |-> $past(WR);
  endproperty
  a_sticky: assert property (p_sticky) else $error("irq fell unasked");
  property p_zero_wr;
    WR && ADDR == 8'h20 && WDATA[8:0] == 9'h000 |=> !$fell(IRQ);
  endproperty
  a_zero_wr: assert property (p_zero_wr) else $error("zero write cleared");
  property p_dbe;
    RD && ADDR == 8'h24 |=> RDATA == {23'h00_0000, dbe_r};
  endproperty
  a_dbe: assert property (p_dbe) else $error("filter enable wrong");
endmodule // gild_checker

/* gild_pin_model.sv */
// partner model: external pin drivers with a glitch option that flips pins while held
module gild_pin_model (
  input wire logic clk,
  input wire logic [8:0] level,
  input wire logic [8:0] glitch,
  output logic [8:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pins = 9'h000;
  // a glitch flips the pin for as long as glitch is held
  always @(posedge clk)
    pins <= level ^ glitch;
endmodule // gild_pin_model

/* tb_top.sv */
// testbench: register and pin scenarios for the gpio irq block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst_n = 0, wr_s = 0, rd_s = 0, irq;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [8:0] level = 9'h000, glitch = 9'h000, pins;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  gild_gpio_irq #(.SLOW_DIV(4)) dut (.MCLK(mclk), .RST_N(rst_n),
    .GPIO_IN(pins), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .IRQ(irq));
  gild_pin_model pm (.clk(mclk), .level(level), .glitch(glitch), .pins(pins));
  initial forever #4 mclk = ~mclk;
  task automatic close_out;
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // tests end well before this; a hang lands here
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      error_cnt++;
      close_out;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // n of zero checks the interrupt at once
  task automatic wt(input logic e, input int n);
    #1;
    for (int i = 0; i < n && irq !== e; i++)
      @(posedge mclk) #1;
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task automatic pin(input logic [8:0] v);
    @(posedge mclk);
    level <= v;
  endtask
  initial
  begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(8'h24, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    rd(8'h00, 32'h0000_0000);
    // only pin 0 may interrupt, the latches cannot be told apart
    wr(8'h3C, 32'h0000_0001);
    wr(8'h30, 32'h0000_0001);
    wr(8'h34, 32'h0000_0001);
    wr(8'h20, 32'h0000_01FF);
    pin(9'h001);
    wt(1'b1, 8);
    wr(8'h20, 32'h0000_01FE);
    wt(1'b1, 0);
    rd(8'h20, 32'h0000_0000);
    wr(8'h20, 32'h0000_0001);
    wt(1'b0, 0);
    wr(8'h38, 32'h0000_0001);
    pin(9'h000);
    wt(1'b1, 8);
    // rising edge reaches the latch in the very cycle the clear is taken
    pin(9'h001);
    wr(8'h20, 32'h0000_0001);
    wt(1'b1, 0);
    wr(8'h20, 32'h0000_0001);
    wr(8'h38, 32'h0000_0000);
    wr(8'h30, 32'h0000_0000);
    pin(9'h001);
    wt(1'b1, 8);
    wr(8'h20, 32'h0000_0001);
    wt(1'b1, 0);
    pin(9'h000);
    repeat (3) @(posedge mclk);
    wr(8'h20, 32'h0000_0001);
    wt(1'b0, 0);
    wr(8'h24, 32'h0000_0001);
    rd(8'h24, 32'h0000_0001);
    wr(8'h30, 32'h0000_0001);
    wr(8'h38, 32'h0000_0001);
    repeat (12) @(posedge mclk);
    wr(8'h20, 32'h0000_01FF);
    glitch <= 9'h001;
    @(posedge mclk);
    glitch <= 9'h000;
    repeat (20) @(posedge mclk);
    wt(1'b0, 0);
    pin(9'h001);
    wt(1'b1, 20);
    pin(9'h1A5);
    repeat (2) @(posedge mclk);
    rd(8'h28, 32'h0000_01A5);
    close_out;
  end
endmodule // tb_top
bind gild_gpio_irq gild_checker #(.PINS(PINS)) u_chk (.MCLK(MCLK),
  .RST_N(RST_N), .GPIO_IN(GPIO_IN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .IRQ(IRQ));
